// ==== logic/sacp_pkg.sv ====
package sacp_pkg;

    // ======================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int CONV_TIME_NS  = 10000;
    localparam int EOC_DELAY_NS  = 200;
    localparam int DEBOUNCE_NS   = 100;
    localparam int CONV_CYC      = (CONV_TIME_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int EOC_DELAY_CYC = (EOC_DELAY_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int DEBOUNCE_CYC  = (DEBOUNCE_NS + CLK_PERIOD_NS - 1)
                                   / CLK_PERIOD_NS;
    localparam int CNT_W         = 11;

    // ======================================================
    // Command and result layout
    localparam logic [3:0] CMD_BITS       = 4'h8;
    localparam logic [4:0] ADDR_FALL      = 5'h04;
    localparam logic [3:0] ADDR_PWR_DOWN  = 4'hE;
    localparam logic [1:0] LEN_CODE_8     = 2'h1;
    localparam logic [1:0] LEN_CODE_16    = 2'h3;
    localparam logic [4:0] LEN_BITS_8     = 5'h08;
    localparam logic [4:0] LEN_BITS_12    = 5'h0C;
    localparam logic [4:0] LEN_BITS_16    = 5'h10;
    localparam int         RES_BITS       = 12;
    localparam logic [3:0] PAD_ZERO       = 4'h0;
    localparam logic       PD_AT_RESET    = 1'h1;

    typedef struct packed {
        logic [3:0] addr;
        logic       length_select_upper;
        logic       length_select_lower;
        logic       lsb_first_select;
        logic       signed_format_select;
    } sacp_cmd_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_HOLD = 3'h2,
        ST_CONV = 3'h4
    } sacp_state_t;

    // Transfer length in shift clocks
    function automatic logic [4:0] sacp_len_bits(input sacp_cmd_t c);
        logic [1:0] code;
        code = {c.length_select_upper, c.length_select_lower};
        if (code == LEN_CODE_8)
            return LEN_BITS_8;
        else if (code == LEN_CODE_16)
            return LEN_BITS_16;
        else
            return LEN_BITS_12;
    endfunction : sacp_len_bits

endpackage : sacp_pkg

// ==== logic/sacp_top.sv ====
`timescale 1ns/1ps
module sacp_top (
    input  wire logic        MCLK,
    input  wire logic        RST_B,
    input  wire logic        SHIFT_CLK,
    input  wire logic        SELECT_B,
    input  wire logic        CMD_SERIAL_IN,
    input  wire logic [11:0] SAR_CODE,
    output logic             RESULT_SERIAL_OUT,
    output logic             RESULT_SERIAL_OE,
    output logic             CONVERSION_DONE,
    output logic             SAMPLE_ON,
    output logic [3:0]       CHANNEL_SEL,
    output logic             POWER_DOWN
);

    // ======================================================
    // Declarations
    logic                 link_clr_n_r;
    logic                 link_rst_n;
    logic                 lk_live_r;
    logic                 lk_done_r;
    logic [3:0]           lk_rise_cnt_r;
    logic [4:0]           lk_fall_cnt_r;
    logic [7:0]           lk_shift_r;
    logic                 lk_fall_tgl_r;
    logic                 lk_addr_tgl_r;
    logic                 lk_start_tgl_r;
    logic [3:0]           lk_addr_hold_r;
    sacp_pkg::sacp_cmd_t  lk_cmd_hold_r;
    sacp_pkg::sacp_cmd_t  lk_cmd_cur;
    logic                 lk_fall_ok;
    logic [4:0]           lk_fall_num;
    logic                 lk_last;

    logic [2:0]           tg_s1_r;
    logic [2:0]           tg_s2_r;
    logic [2:0]           tg_s3_r;
    logic                 fall_ev;
    logic                 addr_ev;
    logic                 start_ev;
    logic                 cs_s1_r;
    logic                 cs_s2_r;
    logic                 cs_deb_r;
    logic                 sel_ev_r;
    logic [sacp_pkg::CNT_W-1:0] deb_cnt_r;
    logic [11:0]          sar_s1_r;
    logic [11:0]          sar_s2_r;

    sacp_pkg::sacp_state_t state_r;
    sacp_pkg::sacp_state_t state_nxt;
    logic [sacp_pkg::CNT_W-1:0] cnt_r;
    logic [sacp_pkg::CNT_W-1:0] cnt_nxt;
    sacp_pkg::sacp_cmd_t  cmd_act_r;
    logic                 conv_end;
    logic                 pd_end;
    logic                 pd_r;
    logic                 sample_r;
    logic [3:0]           chan_r;
    logic                 eoc_r;
    logic [15:0]          word_r;
    logic [15:0]          word_nxt;
    logic [15:0]          shift_r;
    logic                 dout_r;
    logic                 oe_r;

    // ======================================================
    // Output word build
    function automatic logic [15:0] build_word(
        input logic [11:0]         code,
        input sacp_pkg::sacp_cmd_t c
    );
        logic [11:0] res;
        logic [11:0] rev;
        logic [4:0]  len;
        res = code;
        rev = '0;
        len = sacp_pkg::sacp_len_bits(c);
        if (c.signed_format_select)
            res[11] = ~code[11];
        for (int i = 0; i < sacp_pkg::RES_BITS; i++)
            rev[i] = res[sacp_pkg::RES_BITS - 1 - i];
        if (!c.lsb_first_select && len == sacp_pkg::LEN_BITS_8)
            return {res[11:4], 8'h00};
        else if (!c.lsb_first_select)
            return {res, sacp_pkg::PAD_ZERO};
        else if (len == sacp_pkg::LEN_BITS_8)
            return {rev[7:0], 8'h00};
        else if (len == sacp_pkg::LEN_BITS_16)
            return {sacp_pkg::PAD_ZERO, rev};
        else
            return {rev, sacp_pkg::PAD_ZERO};
    endfunction : build_word

    // ======================================================
    // Link domain: command shift on rising shift clock
    assign link_rst_n = RST_B & link_clr_n_r;
    assign lk_cmd_cur = lk_shift_r;

    always_ff @(posedge SHIFT_CLK or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            lk_live_r     <= 1'b0;
            lk_rise_cnt_r <= 4'h0;
            lk_shift_r    <= 8'h00;
        end
        else
        begin
            lk_live_r <= 1'b1;
            if (lk_rise_cnt_r != sacp_pkg::CMD_BITS)
            begin
                lk_shift_r    <= {lk_shift_r[6:0], CMD_SERIAL_IN};
                lk_rise_cnt_r <= lk_rise_cnt_r + 4'h1;
            end
        end
    end

    // ======================================================
    // Link domain: falling edge count and frame end
    assign lk_fall_ok  = lk_live_r & ~lk_done_r;
    assign lk_fall_num = lk_fall_cnt_r + 5'h01;
    assign lk_last     = lk_fall_ok
                         && (lk_rise_cnt_r == sacp_pkg::CMD_BITS)
                         && (lk_fall_num
                             == sacp_pkg::sacp_len_bits(lk_cmd_cur));

    always_ff @(negedge SHIFT_CLK or negedge link_rst_n)
    begin
        if (!link_rst_n)
        begin
            lk_fall_cnt_r <= 5'h00;
            lk_done_r     <= 1'b0;
        end
        else
        begin
            if (lk_fall_ok)
                lk_fall_cnt_r <= lk_fall_num;
            if (lk_last)
                lk_done_r <= 1'b1;
        end
    end

    // Event toggles survive link clears so no false event is seen
    always_ff @(negedge SHIFT_CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            lk_fall_tgl_r  <= 1'b0;
            lk_addr_tgl_r  <= 1'b0;
            lk_start_tgl_r <= 1'b0;
            lk_addr_hold_r <= 4'h0;
            lk_cmd_hold_r  <= '0;
        end
        else
        begin
            if (lk_fall_ok)
                lk_fall_tgl_r <= ~lk_fall_tgl_r;
            if (lk_fall_ok && lk_fall_num == sacp_pkg::ADDR_FALL)
            begin
                lk_addr_hold_r <= lk_shift_r[3:0];
                lk_addr_tgl_r  <= ~lk_addr_tgl_r;
            end
            if (lk_last)
            begin
                lk_cmd_hold_r  <= lk_cmd_cur;
                lk_start_tgl_r <= ~lk_start_tgl_r;
            end
        end
    end

    // ======================================================
    // Crossings into the system clock
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            tg_s1_r  <= 3'h0;
            tg_s2_r  <= 3'h0;
            tg_s3_r  <= 3'h0;
            cs_s1_r  <= 1'b1;
            cs_s2_r  <= 1'b1;
            sar_s1_r <= 12'h000;
            sar_s2_r <= 12'h000;
        end
        else
        begin
            tg_s1_r  <= {lk_start_tgl_r, lk_addr_tgl_r, lk_fall_tgl_r};
            tg_s2_r  <= tg_s1_r;
            tg_s3_r  <= tg_s2_r;
            cs_s1_r  <= SELECT_B;
            cs_s2_r  <= cs_s1_r;
            sar_s1_r <= SAR_CODE;
            sar_s2_r <= sar_s1_r;
        end
    end

    assign fall_ev  = tg_s2_r[0] ^ tg_s3_r[0];
    assign addr_ev  = tg_s2_r[1] ^ tg_s3_r[1];
    assign start_ev = tg_s2_r[2] ^ tg_s3_r[2];

    // ======================================================
    // Select debounce
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            cs_deb_r  <= 1'b1;
            deb_cnt_r <= '0;
            sel_ev_r  <= 1'b0;
        end
        else
        begin
            sel_ev_r <= 1'b0;
            if (cs_s2_r == cs_deb_r)
                deb_cnt_r <= '0;
            else if (deb_cnt_r
                     == sacp_pkg::CNT_W'(sacp_pkg::DEBOUNCE_CYC - 1))
            begin
                deb_cnt_r <= '0;
                cs_deb_r  <= cs_s2_r;
                sel_ev_r  <= ~cs_s2_r;
            end
            else
                deb_cnt_r <= deb_cnt_r + 1'b1;
        end
    end

    // ======================================================
    // Conversion sequencer
    assign conv_end = (state_r == sacp_pkg::ST_CONV)
                      && (cnt_r
                          == sacp_pkg::CNT_W'(sacp_pkg::CONV_CYC - 1));
    assign pd_end   = start_ev && (state_r == sacp_pkg::ST_IDLE) && pd_r;

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r + 1'b1;
        case (state_r)
            sacp_pkg::ST_IDLE:
            begin
                cnt_nxt = '0;
                if (start_ev && !pd_r)
                    state_nxt = sacp_pkg::ST_HOLD;
            end
            sacp_pkg::ST_HOLD:
            begin
                if (cnt_r
                    == sacp_pkg::CNT_W'(sacp_pkg::EOC_DELAY_CYC - 1))
                begin
                    state_nxt = sacp_pkg::ST_CONV;
                    cnt_nxt   = '0;
                end
            end
            sacp_pkg::ST_CONV:
            begin
                if (conv_end)
                    state_nxt = sacp_pkg::ST_IDLE;
            end
            default:
            begin
                state_nxt = sacp_pkg::ST_IDLE;
                cnt_nxt   = '0;
            end
        endcase
        if (sel_ev_r)
        begin
            state_nxt = sacp_pkg::ST_IDLE;
            cnt_nxt   = '0;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            state_r <= sacp_pkg::ST_IDLE;
            cnt_r   <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            cmd_act_r <= '0;
        else if (start_ev && state_r == sacp_pkg::ST_IDLE)
            cmd_act_r <= lk_cmd_hold_r;
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            eoc_r <= 1'b1;
        else
            eoc_r <= (state_nxt != sacp_pkg::ST_CONV);
    end

    // Link is held clear while deselected, and cleared per frame
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            link_clr_n_r <= 1'b0;
        else
            link_clr_n_r <= ~(cs_deb_r | sel_ev_r | conv_end
                              | pd_end);
    end

    // ======================================================
    // Power-down, channel and sampling switch
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            pd_r     <= sacp_pkg::PD_AT_RESET;
            chan_r   <= 4'h0;
            sample_r <= 1'b0;
        end
        else
        begin
            if (addr_ev)
            begin
                pd_r <= (lk_addr_hold_r == sacp_pkg::ADDR_PWR_DOWN);
                if (lk_addr_hold_r != sacp_pkg::ADDR_PWR_DOWN)
                begin
                    chan_r   <= lk_addr_hold_r;
                    sample_r <= 1'b1;
                end
            end
            else if (sel_ev_r || state_nxt == sacp_pkg::ST_CONV)
                sample_r <= 1'b0;
        end
    end

    // ======================================================
    // Result store and serial output
    assign word_nxt = build_word(sar_s2_r, cmd_act_r);

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            word_r <= 16'h0000;
        else if (conv_end && !sel_ev_r)
            word_r <= word_nxt;
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            shift_r <= 16'h0000;
            dout_r  <= 1'b0;
        end
        else if (sel_ev_r || pd_end)
        begin
            shift_r <= word_r;
            dout_r  <= word_r[15];
        end
        else if (conv_end)
        begin
            shift_r <= word_nxt;
            dout_r  <= word_nxt[15];
        end
        else if (state_nxt != sacp_pkg::ST_IDLE)
            dout_r <= 1'b0;
        else if (fall_ev)
        begin
            shift_r <= {shift_r[14:0], 1'b0};
            dout_r  <= shift_r[14];
        end
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            oe_r <= 1'b0;
        else
            oe_r <= ~cs_s2_r;
    end

    // ======================================================
    // Outputs
    assign RESULT_SERIAL_OUT = dout_r;
    assign RESULT_SERIAL_OE  = oe_r;
    assign CONVERSION_DONE   = eoc_r;
    assign SAMPLE_ON         = sample_r;
    assign CHANNEL_SEL       = chan_r;
    assign POWER_DOWN        = pd_r;

endmodule : sacp_top

// ==== sim/sacp_checker.sv ====
`timescale 1ns/1ps
// ======================================================
// Port checker
module sacp_checker (
    input wire logic MCLK,
    input wire logic RST_B,
    input wire logic SELECT_B,
    input wire logic RESULT_SERIAL_OUT,
    input wire logic RESULT_SERIAL_OE,
    input wire logic CONVERSION_DONE,
    input wire logic SAMPLE_ON,
    input wire logic POWER_DOWN
);
    logic [11:0] low_cnt_r;
    logic        sel_seen_r;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RST_B);

    // ======================================================
    // Helper counters
    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            low_cnt_r <= 12'h000;
        else if (CONVERSION_DONE)
            low_cnt_r <= 12'h000;
        else
            low_cnt_r <= low_cnt_r + 12'h001;
    end

    always_ff @(posedge MCLK or negedge RST_B)
    begin
        if (!RST_B)
            sel_seen_r <= 1'b0;
        else if (CONVERSION_DONE)
            sel_seen_r <= 1'b0;
        else if (SELECT_B)
            sel_seen_r <= 1'b1;
    end

    // ======================================================
    // Assertions
    a_start_pd: assert property (
        $rose(RST_B) |-> POWER_DOWN && CONVERSION_DONE)
        else $error("Not idle in power-down after reset");
    a_conv_len: assert property (
        $rose(CONVERSION_DONE) && !sel_seen_r
            |-> low_cnt_r == sacp_pkg::CONV_CYC)
        else $error("Conversion time wrong");
    a_dout_zero: assert property (
        !CONVERSION_DONE |-> !RESULT_SERIAL_OUT)
        else $error("Data out not zero during conversion");
    a_sample_done: assert property (
        SAMPLE_ON |-> CONVERSION_DONE)
        else $error("Done low while sampling");
    a_fall_after_sample: assert property (
        $fell(CONVERSION_DONE) |-> $past(SAMPLE_ON))
        else $error("Conversion began without sampling");
    a_desel_float: assert property (
        $rose(SELECT_B) |-> ##[1:4] !RESULT_SERIAL_OE)
        else $error("Output not released on deselect");
    a_sel_drive: assert property (
        $fell(SELECT_B) |-> ##[1:4] RESULT_SERIAL_OE)
        else $error("Output not driven on select");
    a_pd_no_conv: assert property (
        POWER_DOWN |-> CONVERSION_DONE)
        else $error("Conversion running in power-down");
    a_reselect_reset: assert property (
        $fell(SELECT_B) ##1 !SELECT_B [*8] |-> ##[1:12] CONVERSION_DONE)
        else $error("No reset after reselect");
endmodule : sacp_checker

bind sacp_top sacp_checker i_chk (
    .MCLK              (MCLK),
    .RST_B             (RST_B),
    .SELECT_B          (SELECT_B),
    .RESULT_SERIAL_OUT (RESULT_SERIAL_OUT),
    .RESULT_SERIAL_OE  (RESULT_SERIAL_OE),
    .CONVERSION_DONE   (CONVERSION_DONE),
    .SAMPLE_ON         (SAMPLE_ON),
    .POWER_DOWN        (POWER_DOWN)
);

// ==== sim/sacp_host_model.sv ====
`timescale 1ns/1ps
// ======================================================
// Host side of the serial link
module sacp_host_model (
    output logic      SHIFT_CLK,
    output logic      SELECT_B,
    output logic      CMD_SERIAL_IN,
    input wire logic  RESULT_SERIAL_OUT
);
    initial
    begin
        SHIFT_CLK     = 1'b0;
        SELECT_B      = 1'b1;
        CMD_SERIAL_IN = 1'b0;
    end

    function automatic int frame_len(input logic [7:0] c);
        return (c[3:2] == 2'h1) ? 8 : (c[3:2] == 2'h3) ? 16 : 12;
    endfunction : frame_len

    task automatic set_select(input logic lvl);
        SELECT_B <= lvl;
    endtask : set_select

    // ======================================================
    // One whole frame, 48 ns clock; first result bit lands in rd[15]
    task automatic xfer(input logic [7:0] cmd, output logic [15:0] rd);
        int n;
        n  = frame_len(cmd);
        rd = 16'h0000;
        #3.3;
        CMD_SERIAL_IN = cmd[7];
        #2;
        for (int k = 0; k < n; k++)
        begin
            SHIFT_CLK = 1'b1;
            #23;
            rd[15 - k] = RESULT_SERIAL_OUT;
            #1;
            SHIFT_CLK = 1'b0;
            #2;
            if (k < 7)
                CMD_SERIAL_IN = cmd[6 - k]; // later bits held
            #22;
        end
    endtask : xfer
endmodule : sacp_host_model

// ==== sim/sacp_tb.sv ====
`timescale 1ns/1ps
// ======================================================
// Testbench
module tb;
    logic        MCLK = 1'b0;
    logic        RST_B;
    logic [11:0] SAR_CODE;
    logic        SHIFT_CLK;
    logic        SELECT_B;
    logic        CMD_SERIAL_IN;
    logic        RESULT_SERIAL_OUT;
    logic        RESULT_SERIAL_OE;
    logic        CONVERSION_DONE;
    logic        SAMPLE_ON;
    logic [3:0]  CHANNEL_SEL;
    logic        POWER_DOWN;
    logic        dout_line;
    logic [15:0] rd;
    logic [15:0] e;
    logic [7:0]  c;
    logic [7:0]  lc = 8'h00;
    logic [11:0] ls = 12'h000;
    logic        have = 1'b0;
    int          num_errors = 0;
    int          comparisons = 0;
    logic [7:0]  cmd_tab [12] = '{8'h10, 8'h27, 8'h3E, 8'hAD, 8'hB9,
        8'hC6, 8'hD2, 8'h04, 8'hE0, 8'h1C, 8'h1C, 8'h10};
    logic [11:0] sar_tab [12] = '{12'hA5C, 12'h3C1, 12'h812, 12'hF0F,
        12'h800, 12'h7FE, 12'h001, 12'h6B3, 12'h555, 12'h9A7, 12'h2D4,
        12'h0F0};

    always #5 MCLK = ~MCLK;

    // Released line shows the inverse so a stale bit cannot pass
    assign dout_line = RESULT_SERIAL_OE ? RESULT_SERIAL_OUT : ~RESULT_SERIAL_OUT;

    sacp_top i_dut (
        .MCLK              (MCLK),
        .RST_B             (RST_B),
        .SHIFT_CLK         (SHIFT_CLK),
        .SELECT_B          (SELECT_B),
        .CMD_SERIAL_IN     (CMD_SERIAL_IN),
        .SAR_CODE          (SAR_CODE),
        .RESULT_SERIAL_OUT (RESULT_SERIAL_OUT),
        .RESULT_SERIAL_OE  (RESULT_SERIAL_OE),
        .CONVERSION_DONE   (CONVERSION_DONE),
        .SAMPLE_ON         (SAMPLE_ON),
        .CHANNEL_SEL       (CHANNEL_SEL),
        .POWER_DOWN        (POWER_DOWN)
    );

    sacp_host_model i_host (
        .SHIFT_CLK         (SHIFT_CLK),
        .SELECT_B          (SELECT_B),
        .CMD_SERIAL_IN     (CMD_SERIAL_IN),
        .RESULT_SERIAL_OUT (dout_line)
    );

    // ======================================================
    // Helpers
    task automatic cyc(input int n);
        repeat (n) @(posedge MCLK);
    endtask : cyc

    task automatic chk(input string name, input logic [15:0] ex,
                       input logic [15:0] got);
        comparisons++;
        if (got !== ex)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, ex, got);
        end
    endtask : chk

    function automatic int flen(input logic [7:0] cm);
        return (cm[3:2] == 2'h1) ? 8 : (cm[3:2] == 2'h3) ? 16 : 12;
    endfunction : flen

    // Serial stream of a stored result, first bit at the top
    function automatic logic [15:0] exp_stream(input logic [7:0] cm,
        input logic [11:0] sar, input int n);
        logic [11:0] r;
        logic [15:0] s;
        int          len;
        r     = sar;
        r[11] = r[11] ^ cm[0];
        len   = flen(cm);
        s     = {r, 4'h0};
        if (cm[1])
        begin
            for (int k = 0; k < 12; k++)
                s[15 - k] = r[k];
            s[3:0] = 4'h0;
            if (len == 16)
                s = s >> 4;
            else if (len == 8)
                s = s << 4;
        end
        if (n > len)
            n = len;
        return s & ~(16'hFFFF >> n);
    endfunction : exp_stream

    task automatic wait_done(input logic [7:0] cm, input logic [11:0] sar);
        int k;
        k = 0;
        while (CONVERSION_DONE === 1'b1 && k < 100)
        begin
            @(negedge MCLK);
            k++;
        end
        chk("done_low", 16'h0000, 16'(CONVERSION_DONE));
        cyc(500);
        @(negedge MCLK);
        chk("dout_conv", 16'h0000, 16'(RESULT_SERIAL_OUT));
        k = 0;
        while (CONVERSION_DONE !== 1'b1 && k < 1100)
        begin
            @(negedge MCLK);
            k++;
        end
        chk("done_high", 16'h0001, 16'(CONVERSION_DONE));
        e = exp_stream(cm, sar, 1);
        chk("first_bit", 16'(e[15]), 16'(RESULT_SERIAL_OUT));
    endtask : wait_done

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    // ======================================================
    // Watchdog
    initial
    begin
        #500000;
        num_errors++;
        give_verdict();
    end

    // ======================================================
    // Main sequence
    initial
    begin
        RST_B    = 1'b0;
        SAR_CODE = 12'h000;
        cyc(16);
        RST_B <= 1'b1;
        cyc(2);
        @(negedge MCLK);
        chk("pd_reset", 16'h0001, 16'(POWER_DOWN));
        chk("done_reset", 16'h0001, 16'(CONVERSION_DONE));
        chk("oe_desel", 16'h0000, 16'(RESULT_SERIAL_OE));
        cyc(1);
        i_host.set_select(1'b0);
        cyc(25);
        for (int i = 0; i < 12; i++)
        begin
            c = cmd_tab[i];
            cyc(3);
            SAR_CODE <= sar_tab[i];
            i_host.xfer(c, rd);
            e = exp_stream(lc, ls, flen(c));
            if (have)
                chk("rx", e, rd);
            cyc(8);
            @(negedge MCLK);
            chk("pd", 16'(c[7:4] == 4'hE), 16'(POWER_DOWN));
            chk("sample", 16'(c[7:4] != 4'hE), 16'(SAMPLE_ON));
            if (c[7:4] == 4'hE)
                chk("done_pd", 16'h0001, 16'(CONVERSION_DONE));
            else
            begin
                chk("chan", 16'(c[7:4]), 16'(CHANNEL_SEL));
                if (i == 10)
                begin
                    cyc(100);
                    i_host.set_select(1'b1);
                    cyc(6);
                    @(negedge MCLK);
                    chk("oe_abort", 16'h0000, 16'(RESULT_SERIAL_OE));
                    cyc(12);
                    i_host.set_select(1'b0);
                    cyc(25);
                    @(negedge MCLK);
                    chk("done_sel", 16'h0001, 16'(CONVERSION_DONE));
                    e = exp_stream(lc, ls, 1);
                    chk("kept", 16'(e[15]), 16'(RESULT_SERIAL_OUT));
                end
                else
                begin
                    wait_done(c, sar_tab[i]);
                    lc   = c;
                    ls   = sar_tab[i];
                    have = 1'b1;
                end
            end
        end
        give_verdict();
    end
endmodule : tb
